// ---- hdl/pmpc_regs.v ----
/*
 Dual-channel pulse metering, polarity reversal and indirect memory
 register bank behind the control serial port. Assumes the analog side
 reports line polarity per channel and consumes the wink and reversal
 controls; everything runs on ref_clk.
*/
`timescale 1ns/1ps
`include "pmpc_map.vh"
module pmpc_regs #(
   parameter MEM_UPDATE_CYCLES = `PMPC_MEM_UPDATE_CYCLES
) (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire       ce,
   input  wire       spi_sclk,
   input  wire       spi_cs_n,
   input  wire       spi_sdi,
   output wire       spi_sdo,
   output wire       spi_sdo_oe,
   input  wire [1:0] line_reverse,
   output wire [1:0] metering_waveform,
   output wire [1:0] wink_enable,
   output wire [1:0] smooth_reversal_enable,
   output wire [1:0] ramp_fast
);
   localparam integer TICK_LAST_I = `PMPC_TICK_CYCLES - 1;
   localparam integer UPD_LAST_I  = MEM_UPDATE_CYCLES - 1;
   // both counts fit their counters; cut to counter width on purpose
   localparam [5:0]   TICK_LAST   = TICK_LAST_I[5:0];
   localparam [7:0]   UPD_LAST    = UPD_LAST_I[7:0];

   wire        bus_chan;
   wire [7:0]  bus_addr;
   wire [7:0]  wr_data;
   wire        wr_strobe;
   reg  [7:0]  rd_data;
   wire [15:0] ch_rd;

   reg  [5:0]  tick_cnt;
   wire        tick = (tick_cnt == TICK_LAST);
   reg  [7:0]  upd_cnt;
   wire        mem_update = (upd_cnt == UPD_LAST);

   reg  [7:0]  indirect_address;
   reg  [15:0] indirect_data;
   reg         indirect_busy;
   reg         pend_write;
   reg         data_loaded;
   reg  [15:0] ram [0:`PMPC_MEM_DEPTH-1];
   integer     i;

   wire        shared_wr = wr_strobe;
   wire        addr_wr   = shared_wr && bus_addr == `PMPC_ADDR_IND_ADDR;
   wire        dlo_wr    = shared_wr && bus_addr == `PMPC_ADDR_IND_DATA_LO;
   wire        dhi_wr    = shared_wr && bus_addr == `PMPC_ADDR_IND_DATA_HI;
   wire        do_update = mem_update && indirect_busy;

   pmpc_spi_slave u_spi (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .ce         (ce),
      .spi_sclk   (spi_sclk),
      .spi_cs_n   (spi_cs_n),
      .spi_sdi    (spi_sdi),
      .spi_sdo    (spi_sdo),
      .spi_sdo_oe (spi_sdo_oe),
      .bus_chan   (bus_chan),
      .bus_addr   (bus_addr),
      .wr_data    (wr_data),
      .wr_strobe  (wr_strobe),
      .rd_data    (rd_data)
   );

   // one count period, rounded up to whole cycles
   always @(posedge ref_clk)
   begin
      if (reset)
         tick_cnt <= 6'h00;
      else if (ce)
         tick_cnt <= tick ? 6'h00 : tick_cnt + 6'h01;
   end

   // free-running memory update strobe
   always @(posedge ref_clk)
   begin
      if (reset)
         upd_cnt <= 8'h00;
      else if (ce)
         upd_cnt <= mem_update ? 8'h00 : upd_cnt + 8'h01;
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_chan
         reg  [2:0]  mtr_ctrl;
         reg  [15:0] act_count;
         reg  [15:0] inact_count;
         reg  [2:0]  pol_ctrl;
         reg  [7:0]  rv;
         wire        hit = wr_strobe && bus_chan == g;
         wire        wave;

         always @(posedge ref_clk)
         begin
            if (reset)
            begin
               mtr_ctrl    <= 3'h0;
               act_count   <= `PMPC_RST_WORD;
               inact_count <= `PMPC_RST_WORD;
               pol_ctrl    <= 3'h0;
            end
            else if (ce && hit)
            begin
               case (bus_addr)
                  `PMPC_ADDR_MTR_CTRL:
                     mtr_ctrl <= wr_data[`PMPC_BIT_ACT_TMR_EN:`PMPC_BIT_MTR_EN];
                  `PMPC_ADDR_MTR_ACT_LO:
                     act_count[7:0] <= wr_data;
                  `PMPC_ADDR_MTR_ACT_HI:
                     act_count[15:8] <= wr_data;
                  `PMPC_ADDR_MTR_INACT_LO:
                     inact_count[7:0] <= wr_data;
                  `PMPC_ADDR_MTR_INACT_HI:
                     inact_count[15:8] <= wr_data;
                  `PMPC_ADDR_POLARITY:
                     pol_ctrl <= wr_data[`PMPC_BIT_WINK_EN:`PMPC_BIT_RAMP_FAST];
                  default:
                     pol_ctrl <= pol_ctrl;
               endcase
            end
         end

         pmpc_cadence u_cad (
            .ref_clk     (ref_clk),
            .reset       (reset),
            .ce          (ce),
            .tick        (tick),
            .enable      (mtr_ctrl[0]),
            .act_en      (mtr_ctrl[2]),
            .inact_en    (mtr_ctrl[1]),
            .act_count   (act_count),
            .inact_count (inact_count),
            .waveform    (wave)
         );

         assign metering_waveform[g]      = wave;
         assign wink_enable[g]            = pol_ctrl[2];
         assign smooth_reversal_enable[g] = pol_ctrl[1];
         assign ramp_fast[g]              = pol_ctrl[0];

         // per-channel read view; reserved bits read as zero
         always @*
         begin
            rv = `PMPC_RST_BYTE;
            case (bus_addr)
               `PMPC_ADDR_MTR_CTRL:
               begin
                  rv[`PMPC_BIT_WAVE_PRESENT] = wave;
                  rv[`PMPC_BIT_ACT_TMR_EN:`PMPC_BIT_MTR_EN] = mtr_ctrl;
               end
               `PMPC_ADDR_MTR_ACT_LO:
                  rv = act_count[7:0];
               `PMPC_ADDR_MTR_ACT_HI:
                  rv = act_count[15:8];
               `PMPC_ADDR_MTR_INACT_LO:
                  rv = inact_count[7:0];
               `PMPC_ADDR_MTR_INACT_HI:
                  rv = inact_count[15:8];
               `PMPC_ADDR_POLARITY:
               begin
                  rv[`PMPC_BIT_POL_STATE] = line_reverse[g];
                  rv[`PMPC_BIT_WINK_EN:`PMPC_BIT_RAMP_FAST] = pol_ctrl;
               end
               default:
                  rv = `PMPC_RST_BYTE;
            endcase
         end
         assign ch_rd[8*g +: 8] = rv;
      end
   endgenerate

   // shared indirect access, one copy for both channels
   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         indirect_address <= `PMPC_RST_BYTE;
         indirect_busy    <= 1'b0;
         pend_write       <= 1'b0;
         data_loaded      <= 1'b0;
      end
      else if (ce)
      begin
         if (addr_wr)
         begin
            indirect_address <= wr_data;
            pend_write       <= data_loaded;
            data_loaded      <= 1'b0;
         end
         else if (dlo_wr || dhi_wr)
            data_loaded <= 1'b1;
         // a new address write wins over completion in the same cycle
         if (addr_wr)
            indirect_busy <= 1'b1;
         else if (do_update)
            indirect_busy <= 1'b0;
      end
   end

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         indirect_data <= `PMPC_RST_WORD;
         for (i = 0; i < `PMPC_MEM_DEPTH; i = i + 1)
            ram[i] <= `PMPC_RST_WORD;
      end
      else if (ce)
      begin
         if (do_update && pend_write)
            ram[indirect_address] <= indirect_data;
         else if (do_update)
            indirect_data <= ram[indirect_address];
         // host byte writes override a read copy landing in the same cycle
         if (dlo_wr)
            indirect_data[7:0] <= wr_data;
         if (dhi_wr)
            indirect_data[15:8] <= wr_data;
      end
   end

   always @*
   begin
      case (bus_addr)
         `PMPC_ADDR_RAM_BUSY:
            rd_data = {7'h00, indirect_busy};
         `PMPC_ADDR_IND_ADDR:
            rd_data = indirect_address;
         `PMPC_ADDR_IND_DATA_LO:
            rd_data = indirect_data[7:0];
         `PMPC_ADDR_IND_DATA_HI:
            rd_data = indirect_data[15:8];
         default:
            rd_data = bus_chan ? ch_rd[15:8] : ch_rd[7:0];
      endcase
   end
endmodule

// ---- hdl/pmpc_map.vh ----
/*
 Register map, field positions, reset values and timing counts of the
 pulse metering and polarity control bank. Definitions only; included by
 the register bank and serial port design files, not by the sequencer.
*/
// Overview of operation
// - metering control bit 7 reads 1 while a metering waveform is generated
// - metering control bit 4 enables the active-period timer
// - metering control bit 3 enables the inactive-period timer
// - metering control bit 2 turns pulse metering on or off
// - metering control resets to zero, metering and both timers off
// - active period is 16 bits, high byte at 30, low byte at 29
// - each active count stands for 1.25 us
// - inactive period is 16 bits at 32 and 31, 1.25 us per count
// - polarity bit 3 reads 0 forward, 1 reverse
// - polarity bit 2 set ramps open-circuit voltage to 0 V as wink
// - polarity bit 1 set enables smooth polarity reversal
// - polarity bit 0 picks slope: 0 gives 1 V, 1 gives 2 V per 1.25 ms
// - data then address write commits data to memory at next update
// - address write alone copies memory word to data at next update
// - memory address register is one instance shared by both channels
// - busy flag reads 1 while an indirect access is pending
// - indirect data word is 16 bits at 102 and 101, reset to zero
`ifndef PMPC_MAP_VH
`define PMPC_MAP_VH

`define PMPC_ADDR_RAM_BUSY      8'h04
`define PMPC_ADDR_POLARITY      8'h07
`define PMPC_ADDR_MTR_CTRL      8'h1c
`define PMPC_ADDR_MTR_ACT_LO    8'h1d
`define PMPC_ADDR_MTR_ACT_HI    8'h1e
`define PMPC_ADDR_MTR_INACT_LO  8'h1f
`define PMPC_ADDR_MTR_INACT_HI  8'h20
`define PMPC_ADDR_IND_DATA_LO   8'h65
`define PMPC_ADDR_IND_DATA_HI   8'h66
`define PMPC_ADDR_IND_ADDR      8'h67

`define PMPC_BIT_WAVE_PRESENT   7
`define PMPC_BIT_ACT_TMR_EN     4
`define PMPC_BIT_INACT_TMR_EN   3
`define PMPC_BIT_MTR_EN         2
`define PMPC_BIT_POL_STATE      3
`define PMPC_BIT_WINK_EN        2
`define PMPC_BIT_SMOOTH_EN      1
`define PMPC_BIT_RAMP_FAST      0
`define PMPC_BIT_SPI_READ       7
`define PMPC_BIT_SPI_CHAN       0

`define PMPC_RST_BYTE           8'h00
`define PMPC_RST_WORD           16'h0000

`define PMPC_LSB_PS             1250000
`define PMPC_CLK_PS             20000
`define PMPC_TICK_CYCLES        ((`PMPC_LSB_PS + `PMPC_CLK_PS - 1) / `PMPC_CLK_PS)
`define PMPC_MEM_UPDATE_CYCLES  8
`define PMPC_MEM_DEPTH          256

`endif

// ---- hdl/pmpc_spi_slave.v ----
/*
 Control serial port of the bank: control byte, address byte, data byte,
 msb first, data taken on rising sclk and driven after falling sclk.
 Assumes the pins are synchronous to ref_clk and sclk holds each level
 for at least two ref_clk cycles.
*/
`timescale 1ns/1ps
`include "pmpc_map.vh"
module pmpc_spi_slave (
   input  wire       ref_clk,
   input  wire       reset,
   input  wire       ce,
   input  wire       spi_sclk,
   input  wire       spi_cs_n,
   input  wire       spi_sdi,
   output wire       spi_sdo,
   output wire       spi_sdo_oe,
   output reg        bus_chan,
   output reg  [7:0] bus_addr,
   output reg  [7:0] wr_data,
   output reg        wr_strobe,
   input  wire [7:0] rd_data
);
   reg       sclk_q;
   reg [2:0] bit_cnt;
   reg [1:0] byte_idx;
   reg [7:0] rx;
   reg [7:0] tx;
   reg       is_read;
   reg       load_tx;
   wire       rise    = ~spi_cs_n & spi_sclk & ~sclk_q;
   wire       fall    = ~spi_cs_n & ~spi_sclk & sclk_q;
   wire [7:0] rx_next = {rx[6:0], spi_sdi};

   assign spi_sdo    = tx[7];
   assign spi_sdo_oe = ~spi_cs_n & is_read & (byte_idx == 2'd2);

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         sclk_q    <= 1'b1;
         bit_cnt   <= 3'h0;
         byte_idx  <= 2'h0;
         rx        <= 8'h00;
         tx        <= 8'h00;
         is_read   <= 1'b0;
         load_tx   <= 1'b0;
         bus_chan  <= 1'b0;
         bus_addr  <= 8'h00;
         wr_data   <= 8'h00;
         wr_strobe <= 1'b0;
      end
      else if (ce)
      begin
         sclk_q    <= spi_sclk;
         wr_strobe <= 1'b0;
         load_tx   <= 1'b0;
         if (spi_cs_n)
         begin
            bit_cnt  <= 3'h0;
            byte_idx <= 2'h0;
         end
         else if (rise)
         begin
            rx      <= rx_next;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
               case (byte_idx)
                  2'd0:
                  begin
                     is_read  <= rx_next[`PMPC_BIT_SPI_READ];
                     bus_chan <= rx_next[`PMPC_BIT_SPI_CHAN];
                     byte_idx <= 2'd1;
                  end
                  2'd1:
                  begin
                     bus_addr <= rx_next;
                     load_tx  <= is_read;
                     byte_idx <= 2'd2;
                  end
                  2'd2:
                  begin
                     wr_data   <= rx_next;
                     wr_strobe <= ~is_read;
                     byte_idx  <= 2'd3;
                  end
                  default:
                     byte_idx <= 2'd3;
               endcase
            end
         end
         // read value is snapshotted once the address has settled
         if (load_tx)
            tx <= rd_data;
         else if (fall && bit_cnt != 3'h0 && byte_idx == 2'd2)
            tx <= {tx[6:0], 1'b0};
      end
   end
endmodule

// ---- hdl/pmpc_cadence.v ----
/*
 Burst and silence sequencer of one metering channel. Assumes tick is a
 one-cycle pulse once per count period from the bank.
*/
`timescale 1ns/1ps
module pmpc_cadence (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        ce,
   input  wire        tick,
   input  wire        enable,
   input  wire        act_en,
   input  wire        inact_en,
   input  wire [15:0] act_count,
   input  wire [15:0] inact_count,
   output reg         waveform
);
   localparam [3:0] ST_IDLE  = 4'b0001;
   localparam [3:0] ST_ACT   = 4'b0010;
   localparam [3:0] ST_INACT = 4'b0100;
   localparam [3:0] ST_HOLD  = 4'b1000;
   reg [3:0]  state;
   reg [15:0] elapsed;

   always @(posedge ref_clk)
   begin
      if (reset)
      begin
         state    <= ST_IDLE;
         elapsed  <= 16'h0000;
         waveform <= 1'b0;
      end
      else if (ce)
      begin
         if (!enable)
         begin
            state    <= ST_IDLE;
            elapsed  <= 16'h0000;
            waveform <= 1'b0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  state    <= ST_ACT;
                  elapsed  <= 16'h0000;
                  waveform <= 1'b1;
               end
               ST_ACT:
               begin
                  // no active timer means one endless burst
                  if (act_en && elapsed == act_count)
                  begin
                     elapsed  <= 16'h0000;
                     waveform <= 1'b0;
                     state    <= inact_en ? ST_INACT : ST_HOLD;
                  end
                  else if (act_en && tick)
                     elapsed <= elapsed + 16'h0001;
               end
               ST_INACT:
               begin
                  if (elapsed == inact_count)
                  begin
                     elapsed  <= 16'h0000;
                     waveform <= 1'b1;
                     state    <= ST_ACT;
                  end
                  else if (tick)
                     elapsed <= elapsed + 16'h0001;
               end
               ST_HOLD:
                  waveform <= 1'b0;
               default:
               begin
                  state    <= ST_IDLE;
                  waveform <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- testbench/pmpc_regs_asserts.sv ----
/*
 Port-level checker of the metering and polarity register bank.
 Assumes it is bound to pmpc_regs and sees only its ports.
*/
`timescale 1ns/1ps
module pmpc_regs_chk #(
   parameter MEM_UPDATE_CYCLES = 8
) (
   input wire       ref_clk,
   input wire       reset,
   input wire       ce,
   input wire       spi_sclk,
   input wire       spi_cs_n,
   input wire       spi_sdi,
   input wire       spi_sdo,
   input wire       spi_sdo_oe,
   input wire [1:0] line_reverse,
   input wire [1:0] metering_waveform,
   input wire [1:0] wink_enable,
   input wire [1:0] smooth_reversal_enable,
   input wire [1:0] ramp_fast
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   property p_oe_cs;
      spi_sdo_oe |-> !spi_cs_n;
   endproperty
   a_oe_cs: assert property (p_oe_cs)
      else $error("sdo driven while deselected");
   // sclk high now, one and three samples back: no shift may land there
   property p_sdo_hold;
      spi_sdo_oe && spi_sclk && $past(spi_sclk) && $past(spi_sclk, 3) |-> $stable(spi_sdo);
   endproperty
   a_sdo_hold: assert property (p_sdo_hold)
      else $error("sdo moved while sclk high");
   property p_rst_clear;
      $past(reset) && $past(ce) |-> metering_waveform == 2'b00 && wink_enable == 2'b00
         && smooth_reversal_enable == 2'b00 && ramp_fast == 2'b00;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("outputs not cleared by reset");
   property p_wink_bus;
      !$past(reset) && $changed(wink_enable) |-> $past(spi_cs_n) == 1'b0;
   endproperty
   a_wink_bus: assert property (p_wink_bus)
      else $error("wink changed outside a frame");
   property p_smooth_bus;
      !$past(reset) && $changed(smooth_reversal_enable) |-> $past(spi_cs_n) == 1'b0;
   endproperty
   a_smooth_bus: assert property (p_smooth_bus)
      else $error("smooth enable changed outside a frame");
   property p_ramp_bus;
      !$past(reset) && $changed(ramp_fast) |-> $past(spi_cs_n) == 1'b0;
   endproperty
   a_ramp_bus: assert property (p_ramp_bus)
      else $error("ramp rate changed outside a frame");
   // one frame addresses one channel only
   property p_wink_chan;
      !$past(reset) && $changed(wink_enable[0]) |-> $stable(wink_enable[1]);
   endproperty
   a_wink_chan: assert property (p_wink_chan)
      else $error("both wink channels changed together");
   property p_freeze;
      !ce |=> $stable(metering_waveform) && $stable(wink_enable) && $stable(spi_sdo);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");
endmodule

// ---- testbench/pmpc_host_model.sv ----
/*
 Host processor model on the control serial port, mode 3, msb first.
 Assumes the caller enters xfer just after a rising ref_clk edge.
*/
`timescale 1ns/1ps
module pmpc_host_model (
   input  wire  ref_clk,
   input  wire  spi_sdo,
   input  wire  spi_sdo_oe,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi
);
   // each sclk level lasts 4 ref_clk cycles, twice the minimum
   localparam HALF = 4;
   initial
   begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b1;
   end
   task automatic step(input integer k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic xfer(input logic [7:0] ctl, input logic [7:0] adr, input logic [7:0] dat,
                       output logic [7:0] rdv);
      logic [23:0] bits;
      integer      i;
      bits = {ctl, adr, dat};
      rdv = 8'h00;
      spi_cs_n = 1'b0;
      step(2);
      for (i = 23; i >= 0; i--)
      begin
         spi_sclk = 1'b0;
         spi_sdi = bits[i];
         step(HALF);
         // undriven sdo reads as unknown so it can never match
         if (i < 8) rdv[i] = spi_sdo_oe ? spi_sdo : 1'bx;
         spi_sclk = 1'b1;
         step(HALF);
      end
      step(2);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      step(2);
   endtask
endmodule

// ---- testbench/tb_top.sv ----
/*
 Self-checking bench of the register bank: serial frames from the host
 model, expectations from the register map. Assumes pmpc_map.vh.
*/
`timescale 1ns/1ps
`include "pmpc_map.vh"
module tb_top;
   localparam T = `PMPC_TICK_CYCLES;
   logic       ref_clk;
   logic       reset;
   logic       ce;
   logic [1:0] line_reverse;
   wire        spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   wire  [1:0] metering_waveform, wink_enable, smooth_reversal_enable, ramp_fast;
   integer     failures, n_tests, n, i;
   logic [7:0] rv;
   logic [7:0] regs [0:10] = '{8'h04, 8'h07, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h65,
                               8'h66, 8'h67, 8'h30};
   logic [7:0] tbl [0:3] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};

   pmpc_regs #(.MEM_UPDATE_CYCLES(2)) uut (
      .ref_clk(ref_clk), .reset(reset), .ce(ce), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .line_reverse(line_reverse), .metering_waveform(metering_waveform),
      .wink_enable(wink_enable), .smooth_reversal_enable(smooth_reversal_enable),
      .ramp_fast(ramp_fast));
   pmpc_host_model host (
      .ref_clk(ref_clk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task final_report;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task chk_rng(input string what, input integer lo, input integer hi, input integer got);
      n_tests++;
      if (got < lo || got > hi)
      begin
         failures++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task wr(input logic ch, input logic [7:0] adr, input logic [7:0] dat);
      host.xfer({7'h00, ch}, adr, dat, rv);
   endtask
   task rd(input logic ch, input logic [7:0] adr, input logic [7:0] exp);
      host.xfer({7'h40, ch}, adr, 8'h00, rv);
      chk8("register", exp, rv);
   endtask
   task wait_wave(input logic lvl, input integer lim);
      n = 0;
      while (metering_waveform[0] !== lvl)
      begin
         @(posedge ref_clk);
         #1;
         n++;
         if (n > lim)
         begin
            failures++;
            $display("mismatch waveform wait expected %b seen timeout", lvl);
            final_report;
         end
      end
   endtask
   task count_high(input integer cyc);
      n = 0;
      repeat (cyc)
      begin
         @(posedge ref_clk);
         #1;
         if (metering_waveform[0] === 1'b1) n++;
      end
   endtask
   // update period is tiny, so one busy read always suffices
   task poll_idle;
      rd(0, `PMPC_ADDR_RAM_BUSY, 8'h00);
   endtask

   initial
   begin
      reset = 1'b1;
      ce = 1'b1;
      line_reverse = 2'b00;
      failures = 0;
      n_tests = 0;
      repeat (2) @(posedge ref_clk);
      #1 reset = 1'b0;
      for (i = 0; i < 11; i++) rd(0, regs[i], 8'h00);
      for (i = 0; i < 4; i++) wr(1, 8'h1d + i[7:0], tbl[i]);
      for (i = 0; i < 4; i++) rd(1, 8'h1d + i[7:0], tbl[i]);
      rd(0, `PMPC_ADDR_MTR_ACT_LO, 8'h00);
      line_reverse = 2'b01;
      wr(0, `PMPC_ADDR_POLARITY, 8'h07);
      rd(0, `PMPC_ADDR_POLARITY, 8'h0f);
      wr(1, `PMPC_ADDR_POLARITY, 8'hf2);
      rd(1, `PMPC_ADDR_POLARITY, 8'h02);
      chk8("wink", 8'h01, {6'h00, wink_enable});
      chk8("smooth", 8'h03, {6'h00, smooth_reversal_enable});
      chk8("ramp", 8'h01, {6'h00, ramp_fast});
      line_reverse = 2'b10;
      wr(1, `PMPC_ADDR_POLARITY, 8'h05);
      rd(1, `PMPC_ADDR_POLARITY, 8'h0d);
      chk8("wink", 8'h03, {6'h00, wink_enable});
      chk8("smooth", 8'h01, {6'h00, smooth_reversal_enable});
      chk8("ramp", 8'h03, {6'h00, ramp_fast});
      wr(0, `PMPC_ADDR_MTR_ACT_LO, 8'h08);
      wr(0, `PMPC_ADDR_MTR_INACT_LO, 8'h04);
      wr(0, `PMPC_ADDR_MTR_CTRL, 8'hfc);
      rd(0, `PMPC_ADDR_MTR_CTRL, 8'h9c);
      wait_wave(1'b0, 1000);
      wait_wave(1'b1, 1000);
      chk_rng("silence", 3 * T, 4 * T + 2, n);
      wait_wave(1'b0, 1000);
      chk_rng("burst", 7 * T, 8 * T + 2, n);
      rd(0, `PMPC_ADDR_MTR_CTRL, 8'h1c);
      wr(0, `PMPC_ADDR_MTR_CTRL, 8'h00);
      chk8("waveform", 8'h00, {6'h00, metering_waveform});
      wr(0, `PMPC_ADDR_MTR_CTRL, 8'h0c);
      count_high(1100);
      chk_rng("continuous", 1100, 1100, n);
      wr(0, `PMPC_ADDR_MTR_CTRL, 8'h00);
      wr(0, `PMPC_ADDR_MTR_CTRL, 8'h14);
      wait_wave(1'b0, 600);
      ce = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 ce = 1'b1;
      count_high(800);
      chk_rng("held off", 0, 0, n);
      wr(0, `PMPC_ADDR_IND_DATA_LO, 8'h34);
      wr(1, `PMPC_ADDR_IND_DATA_HI, 8'h12);
      wr(0, `PMPC_ADDR_IND_ADDR, 8'h5a);
      poll_idle;
      wr(0, `PMPC_ADDR_IND_DATA_LO, 8'hef);
      wr(0, `PMPC_ADDR_IND_DATA_HI, 8'hbe);
      wr(1, `PMPC_ADDR_IND_ADDR, 8'h00);
      poll_idle;
      wr(1, `PMPC_ADDR_IND_ADDR, 8'h5a);
      poll_idle;
      rd(0, `PMPC_ADDR_IND_DATA_LO, 8'h34);
      rd(1, `PMPC_ADDR_IND_DATA_HI, 8'h12);
      rd(0, `PMPC_ADDR_IND_ADDR, 8'h5a);
      wr(0, `PMPC_ADDR_IND_ADDR, 8'h00);
      poll_idle;
      rd(1, `PMPC_ADDR_IND_DATA_HI, 8'hbe);
      wr(0, 8'h30, 8'hff);
      rd(0, 8'h30, 8'h00);
      reset = 1'b1;
      @(posedge ref_clk);
      #1 reset = 1'b0;
      rd(0, `PMPC_ADDR_MTR_CTRL, 8'h00);
      chk8("wink", 8'h00, {6'h00, wink_enable});
      final_report;
   end
endmodule

bind pmpc_regs pmpc_regs_chk #(.MEM_UPDATE_CYCLES(MEM_UPDATE_CYCLES)) u_chk (
   .ref_clk(ref_clk), .reset(reset), .ce(ce), .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
   .line_reverse(line_reverse), .metering_waveform(metering_waveform),
   .wink_enable(wink_enable), .smooth_reversal_enable(smooth_reversal_enable),
   .ramp_fast(ramp_fast));
